// *** core/pfr_seq.sv ***
// power fail / automatic restart sequencer top
// assumes SENSE_OK is synchronous to CLK; the descriptor switches are static
`include "pfr_cfg.svh"
`timescale 1ns/10ps

// Overview of operation
// - supply-good falling raises a power-fail interrupt request
// - memory inhibit asserts about 8 ms after the power-fail interrupt
// - while inhibit is active every write request is blocked at WRITE_EN
// - after supply returns wait about 0.7 s before supply-good reasserts
// - releasing power clear enters the automatic load sequence
// - load begins by reading the 16-bit load descriptor switches
module pfr_seq
#(
    parameter int INHIBIT_CYC = `PFR_INHIBIT_CYC,
    parameter int RESTORE_CYC = `PFR_RESTORE_CYC
)
(
    input  wire logic                    CLK,
    input  wire logic                    RST,
    input  wire logic                    CE,
    input  wire logic                    SENSE_OK,
    input  wire logic [`PFR_DESC_W-1:0]  LOAD_DESCRIPTOR_SWITCHES,
    input  wire logic                    WRITE_REQ,
    output logic                         WRITE_EN,
    output logic                         POWER_OK,
    output logic                         POWER_FAIL_IRQ,
    output logic                         MEM_INHIBIT,
    output logic                         POWER_CLEAR,
    output pfr_pkg::load_s               LOAD_START
);
    import pfr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    seq_e                   state;
    logic                   t_done;
    logic                   t_start;
    logic [`PFR_CNT_W-1:0]  t_load;

    // states in which the supply counts as present
    function automatic logic is_powered(input seq_e s);
        is_powered = (s == ST_RUN) || (s == ST_LOAD);
    endfunction

    // a drop during restore aborts the delay and returns to inhibit, without a new warning
    assign t_start = (is_powered(state) && !SENSE_OK)
                   || (state == ST_INHIBIT && SENSE_OK);
    assign t_load  = (state == ST_INHIBIT) ? `PFR_CNT_W'(RESTORE_CYC)
                                           : `PFR_CNT_W'(INHIBIT_CYC);

    pfr_delay #(.W(`PFR_CNT_W)) u_delay
    (
        .clk   (CLK),
        .rst   (RST),
        .ce    (CE),
        .start (t_start),
        .abort (state == ST_RESTORE && !SENSE_OK),
        .load  (t_load),
        .done  (t_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // reset lands in inhibit so a supply that is already up still runs the restore delay
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            state <= ST_INHIBIT;
        else if (CE)
        begin
            case (state)
                ST_RUN:
                    if (!SENSE_OK)
                        state <= ST_WARN;
                ST_WARN:
                    if (t_done)
                        state <= ST_INHIBIT;
                ST_INHIBIT:
                    if (SENSE_OK)
                        state <= ST_RESTORE;
                ST_RESTORE:
                    if (!SENSE_OK)
                        state <= ST_INHIBIT;
                    else if (t_done)
                        state <= ST_LOAD;
                ST_LOAD:
                    if (!SENSE_OK)
                        state <= ST_WARN;
                    else
                        state <= ST_RUN;
                default:
                    state <= ST_INHIBIT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // marks the first enabled cycle after reset, when the outputs must sit safe
    logic boot;
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            boot <= 1'b1;
        else if (CE)
            boot <= 1'b0;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            POWER_FAIL_IRQ <= 1'b0;
        else if (CE)
            POWER_FAIL_IRQ <= is_powered(state) && !SENSE_OK;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            MEM_INHIBIT <= 1'b1;
        else if (CE)
            MEM_INHIBIT <= (state == ST_WARN && t_done) || state == ST_INHIBIT
                        || (state == ST_RESTORE && !t_done);
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            WRITE_EN <= 1'b0;
        else if (CE)
            WRITE_EN <= WRITE_REQ && !MEM_INHIBIT
                     && !(state == ST_WARN && t_done) && state != ST_INHIBIT;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            POWER_OK <= 1'b0;
        else if (CE)
            POWER_OK <= SENSE_OK && ((state == ST_RESTORE && t_done)
                     || is_powered(state));
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            POWER_CLEAR <= 1'b1;
        else if (CE)
            POWER_CLEAR <= !POWER_OK || !SENSE_OK;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            LOAD_START <= '0;
        else if (CE)
        begin
            LOAD_START.req <= state == ST_LOAD && SENSE_OK;
            if (state == ST_LOAD)
                LOAD_START.data <= LOAD_DESCRIPTOR_SWITCHES;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_IRQ_ON_DROP: assert property (@(posedge CLK) disable iff (RST)
        CE && state == ST_RUN && !SENSE_OK |=> POWER_FAIL_IRQ)
        else $error("no power-fail interrupt after drop");

    AST_INHIBIT_AFTER_WARN: assert property (@(posedge CLK) disable iff (RST)
        state == ST_WARN |-> !MEM_INHIBIT)
        else $error("inhibit asserted before warning interval ended");

    AST_NO_WRITE_INHIBIT: assert property (@(posedge CLK) disable iff (RST)
        MEM_INHIBIT |-> !WRITE_EN)
        else $error("write passed while inhibited");

    AST_OK_NEEDS_DELAY: assert property (@(posedge CLK) disable iff (RST)
        $rose(POWER_OK) |-> $past(state) == ST_RESTORE || $past(state) == ST_LOAD)
        else $error("supply-good rose without restore delay");

    AST_LOAD_ON_RELEASE: assert property (@(posedge CLK) disable iff (RST)
        LOAD_START.req |-> $past(state) == ST_LOAD)
        else $error("load started outside load state");

    AST_DESC_READ: assert property (@(posedge CLK) disable iff (RST)
        CE && state == ST_LOAD |=> LOAD_START.data == $past(LOAD_DESCRIPTOR_SWITCHES))
        else $error("descriptor not captured");

    AST_CLEAR_WHEN_BAD: assert property (@(posedge CLK) disable iff (RST)
        !POWER_OK |-> POWER_CLEAR)
        else $error("power clear released without supply-good");

    AST_BOOT_CLEAR: assert property (@(posedge CLK) disable iff (RST)
        boot |-> POWER_CLEAR && MEM_INHIBIT)
        else $error("outputs not safe at boot");

    AST_IRQ_ONE_CYCLE: assert property (@(posedge CLK) disable iff (RST)
        CE && POWER_FAIL_IRQ |=> !POWER_FAIL_IRQ)
        else $error("power-fail interrupt longer than one cycle");

    AST_INHIBIT_ENTRY: assert property (@(posedge CLK) disable iff (RST)
        $rose(MEM_INHIBIT) |-> state == ST_INHIBIT)
        else $error("inhibit rose outside the failure path");

    AST_LOAD_ONE_CYCLE: assert property (@(posedge CLK) disable iff (RST)
        CE && LOAD_START.req |=> !LOAD_START.req)
        else $error("load start longer than one cycle");

    AST_LOAD_AFTER_CLEAR: assert property (@(posedge CLK) disable iff (RST)
        LOAD_START.req |-> !POWER_CLEAR && POWER_OK)
        else $error("load started while power clear held");

    AST_CLEAR_RELEASE: assert property (@(posedge CLK) disable iff (RST)
        $fell(POWER_CLEAR) |-> POWER_OK)
        else $error("power clear released without supply-good");
endmodule

// *** core/pfr_cfg.svh ***
// timing counts and widths for the power fail / restart sequencer
// assumes a 20 MHz system clock
`ifndef PFR_CFG_SVH
`define PFR_CFG_SVH

`define PFR_CLK_HZ          20000000
`define PFR_INHIBIT_US      8000
`define PFR_INHIBIT_CYC     ((`PFR_CLK_HZ / 1000000) * `PFR_INHIBIT_US)
`define PFR_RESTORE_MS      700
`define PFR_RESTORE_CYC     ((`PFR_CLK_HZ / 1000) * `PFR_RESTORE_MS)
`define PFR_DESC_W          16
`define PFR_CNT_W           24

`endif

// *** core/pfr_pkg.sv ***
// types shared by the power fail / restart sequencer
// constants live in pfr_cfg.svh
package pfr_pkg;

    typedef enum logic [2:0]
    {
        ST_RUN,
        ST_WARN,
        ST_INHIBIT,
        ST_RESTORE,
        ST_LOAD
    } seq_e;

    typedef struct packed
    {
        logic        req;
        logic [15:0] data;
    } load_s;

endpackage

// *** core/pfr_delay.sv ***
// down counter: pulses done when a started interval has elapsed
// assumes start is a one-cycle pulse; restart reloads
`timescale 1ns/10ps
module pfr_delay
#(
    parameter int W = 24
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic         start,
    input  wire logic         abort,
    input  wire logic [W-1:0] load,
    output logic              done
);
    logic [W-1:0] count;
    logic         busy;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            if (abort)
                busy <= 1'b0;
            else if (start)
            begin
                count <= load;
                busy  <= 1'b1;
            end
            else if (busy)
            begin
                if (count <= W'(1))
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                else
                    count <= count - W'(1);
            end
        end
    end
endmodule

// *** test/pfr_detect_model.sv ***
// model of the supply's fail detect unit: turns a mains command into a sensed level
// assumes the bench drives mains_up off the falling edge
`timescale 1ns/10ps
module pfr_detect_model
(
    input  wire logic clk,
    input  wire logic mains_up,
    output logic      sense_ok
);
    ////////////////////////////////////////////////////////////////////////
    // registered so the level changes only away from the core's sampling edge
    initial sense_ok = 1'b0;
    always @(negedge clk)
    begin
        sense_ok <= mains_up;
    end
endmodule

// *** test/testbench.sv ***
// self-checking bench for the power fail / restart sequencer
// assumes shortened delay parameters; the detect model stands in for the supply
`timescale 1ns/10ps
module testbench;
    import pfr_pkg::*;
    localparam int INH = 20;
    localparam int RES = 40;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        mains = 1'b0;
    logic        wreq = 1'b0;
    logic        ce = 1'b1;
    logic [15:0] sw = 16'h0000;
    logic        sense, wen, pok, irq, minh, pclr, pinh, pok_d, preq, pce;
    load_s       ld;
    logic [15:0] expq[$];
    int          err_total = 0;
    int          checks = 0;
    int          seed = 46;
    int          cyc = 0;
    int          t_irq, t_inh, t_ok;
    int          n_irq = 0;
    ////////////////////////////////////////////////////////////////////////
    always #25 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    always @(negedge clk) wreq <= 1'($random(seed));
    pfr_detect_model pfr_detect_model_inst (.clk(clk), .mains_up(mains), .sense_ok(sense));
    pfr_seq #(.INHIBIT_CYC(INH), .RESTORE_CYC(RES)) pfr_seq_inst
    (
        .CLK(clk), .RST(rst), .CE(ce), .SENSE_OK(sense), .LOAD_DESCRIPTOR_SWITCHES(sw),
        .WRITE_REQ(wreq), .WRITE_EN(wen), .POWER_OK(pok), .POWER_FAIL_IRQ(irq),
        .MEM_INHIBIT(minh), .POWER_CLEAR(pclr), .LOAD_START(ld)
    );
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_rng(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task conclude();
        $display("errors=%0d checks=%0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watcher: timestamps events, takes the oldest expected descriptor on each load
    always @(posedge clk)
    begin
        if (!rst)
        begin
            if (irq === 1'b1) n_irq++;
            if (irq === 1'b1) t_irq = cyc;
            if (minh === 1'b1 && pinh !== 1'b1) t_inh = cyc;
            if (pok === 1'b1 && pok_d !== 1'b1) t_ok = cyc;
            if (minh === 1'b1) chk(wen, 1'b0);
            if (minh === 1'b0 && pinh === 1'b0 && pce === 1'b1) chk(wen, preq);
            if (pok !== 1'b1) chk(pclr, 1'b1);
            if (ld.req === 1'b1)
            begin
                chk(pok, 1'b1);
                chk(ld.data, expq.size() > 0 ? expq.pop_front() : ~sw);
            end
        end
        pinh = minh;
        pok_d = pok;
        preq = wreq;
        pce = ce;
    end
    ////////////////////////////////////////////////////////////////////////
    task wait_on(input int which, input int lim);
        int n;
        n = 0;
        while (n < lim && !(which == 0 ? minh === 1'b1 : pok === 1'b1))
        begin
            @(negedge clk);
            n++;
        end
        if (n >= lim)
        begin
            err_total++;
            conclude();
        end
        else
            // one more edge so the watcher has stamped the event before it is read
            @(negedge clk);
    endtask
    // a glitch while restoring must restart the wait without a second warning
    task power_up(input logic glitch, input logic [15:0] d);
        int t0;
        sw <= d;
        expq.push_back(d);
        mains <= 1'b1;
        t0 = cyc;
        if (glitch)
        begin
            repeat (RES / 2) @(negedge clk);
            mains <= 1'b0;
            repeat (3) @(negedge clk);
            mains <= 1'b1;
            t0 = cyc;
        end
        wait_on(1, RES + 20);
        chk_rng(t_ok - t0, RES, RES + 6);
        repeat (8) @(negedge clk);
        chk(expq.size(), 0);
    endtask
    task cycle_power(input logic [15:0] d, input logic glitch);
        int t0, n0;
        n0 = n_irq;
        mains <= 1'b0;
        t0 = cyc;
        wait_on(0, INH + 20);
        chk_rng(t_irq - t0, 1, 5);
        chk_rng(t_inh - t_irq, INH - 1, INH + 5);
        power_up(glitch, d);
        chk(n_irq, n0 + 1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(negedge clk);
        rst <= 1'b0;
        @(negedge clk);
        power_up(1'b0, 16'hffff);
        // a frozen core must ignore a supply drop
        ce <= 1'b0;
        mains <= 1'b0;
        repeat (6) @(negedge clk);
        mains <= 1'b1;
        repeat (2) @(negedge clk);
        ce <= 1'b1;
        repeat (4) @(negedge clk);
        chk(n_irq, 0);
        chk(minh, 1'b0);
        for (int i = 0; i < 4; i++)
            cycle_power(16'($random(seed)), i[0]);
        // reset with the supply already present must still run the restore delay
        rst <= 1'b1;
        repeat (2) @(negedge clk);
        rst <= 1'b0;
        power_up(1'b0, 16'h5a5a);
        cycle_power(16'h0000, 1'b0);
        conclude();
    end
endmodule
